// ==== hw/pin_sync.sv ====
// three-flop synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // pin and clean level
   input  wire logic pinIn,
   output logic      levelOut
);
   logic [2:0] syncR_r;
   logic [2:0] sync_nxt;
   logic       level_nxt;

   always_comb begin
      sync_nxt  = {syncR_r[1:0], pinIn};
      level_nxt = levelOut;
      // first flop only feeds the second; change counts when second and third agree
      if (syncR_r[1] == syncR_r[2]) begin
         level_nxt = syncR_r[2];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         syncR_r  <= 3'h0;
         levelOut <= 1'b0;
      end else begin
         syncR_r  <= sync_nxt;
         levelOut <= level_nxt;
      end
   end
endmodule : pin_sync

// ==== hw/position_pulse_qualifier.sv ====
// crossing pulse qualifier with wishbone register file
// Operation
// - pulse only starts while reception level exceeds the positioning threshold
// - pulse only after an identifier was decoded without error
// - pulse only once the center voltage has dropped below its threshold
// - pulse output stays active for the configured length
// - after a pulse stay disarmed until level falls below decoding threshold
// - at most one pulse per transponder pass, even on reversal
// - when enabled, measured values are appended to each serial record
// - decoded identifier is made available to the serial output
`timescale 1ns/1ps
`include "position_pulse_defs.svh"
module position_pulse_qualifier
   import position_pulse_pkg::*;
#(
   parameter int LEN_W = 16
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   // front end measurements
   input  wire logic [`LEVEL_W-1:0]  rxLevel,
   input  wire logic [`LEVEL_W-1:0]  centerVolt,
   input  wire logic                 codeValid,
   input  wire logic                 codeError,
   input  wire logic [`CODE_W-1:0]   codeIn,
   input  wire logic [`MEAS_W-1:0]   supplyVolt,
   input  wire logic [`MEAS_W-1:0]   supplyCurr,
   // serial record output
   output logic                      recordValid,
   output logic [`CODE_W-1:0]        recordCode,
   output logic [2*`MEAS_W-1:0]      recordMeas,
   output logic                      recordHasMeas,
   // pulse pin
   input  wire logic                 pulseAckPin,
   output logic                      crossingPulse,
   // wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [`ADDR_W-1:0]   wb_adr_i,
   input  wire logic [31:0]          wb_dat_i,
   input  wire logic [3:0]           wb_sel_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      wb_err_o
);
   if (LEN_W < 1 || LEN_W > 16) begin : gen_len_check
      $error("LEN_W must be 1..16");
   end

   qual_state_e              state_r, state_nxt;
   logic [LEN_W-1:0]         cnt_r, cnt_nxt;
   logic                     decoded_r, decoded_nxt;
   logic                     pulse_nxt;
   logic [31:0]              ctrl_r, ctrl_nxt;
   logic [`LEVEL_W-1:0]      posLvl_r, posLvl_nxt;
   logic [`LEVEL_W-1:0]      decLvl_r, decLvl_nxt;
   logic [`LEVEL_W-1:0]      ctrLvl_r, ctrLvl_nxt;
   logic [LEN_W-1:0]         len_r, len_nxt;
   logic [15:0]              count_r, count_nxt;
   logic [31:0]              rdat_nxt;
   logic                     ack_nxt, err_nxt;
   logic                     recV_nxt, recM_nxt;
   logic [`CODE_W-1:0]       recC_nxt;
   logic [2*`MEAS_W-1:0]     recMe_nxt;
   logic                     ackLevel;
   logic                     goodCode, qualified, wbReq, mapped;

   // pulse return pin is asynchronous, only read back for status
   pin_sync ackSync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .pinIn    (pulseAckPin),
      .levelOut (ackLevel)
   );

   assign goodCode  = codeValid && !codeError;
   assign qualified = (rxLevel > posLvl_r)
                      && (decoded_r || goodCode)
                      && (centerVolt < ctrLvl_r)
                      && ctrl_r[`CTRL_ENABLE_BIT];
   assign wbReq     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

   // pulse state machine
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      decoded_nxt = decoded_r;
      pulse_nxt   = 1'b0;
      count_nxt   = count_r;
      if (goodCode) decoded_nxt = 1'b1;
      case (state_r)
         ARMED: begin
            if (qualified && len_r != '0) begin
               state_nxt = PULSING;
               cnt_nxt   = len_r - 1'b1;
               pulse_nxt = 1'b1;
               count_nxt = count_r + 16'h0001;
            end
         end
         PULSING: begin
            pulse_nxt = 1'b1;
            if (cnt_r == '0) begin
               state_nxt = SPENT;
               pulse_nxt = 1'b0;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         SPENT: begin
            // reversal over the center cannot rearm: only leaving the field does
            if (rxLevel < decLvl_r) begin
               state_nxt   = ARMED;
               decoded_nxt = goodCode;
            end
         end
         default: state_nxt = ARMED;
      endcase
      // leaving the field also drops a stale decode
      if (state_r == ARMED && rxLevel < decLvl_r && !goodCode) decoded_nxt = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r       <= ARMED;
         cnt_r         <= '0;
         decoded_r     <= 1'b0;
         crossingPulse <= 1'b0;
         count_r       <= 16'h0000;
      end else begin
         state_r       <= state_nxt;
         cnt_r         <= cnt_nxt;
         decoded_r     <= decoded_nxt;
         crossingPulse <= pulse_nxt;
         count_r       <= count_nxt;
      end
   end

   // serial record: code tagged with optional measurements
   always_comb begin
      recV_nxt  = goodCode;
      recC_nxt  = goodCode ? codeIn : recordCode;
      recM_nxt  = goodCode ? ctrl_r[`CTRL_APPEND_BIT] : recordHasMeas;
      recMe_nxt = recordMeas;
      if (goodCode) begin
         recMe_nxt = ctrl_r[`CTRL_APPEND_BIT] ? {supplyVolt, supplyCurr} : '0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         recordValid   <= 1'b0;
         recordCode    <= '0;
         recordHasMeas <= 1'b0;
         recordMeas    <= '0;
      end else begin
         recordValid   <= recV_nxt;
         recordCode    <= recC_nxt;
         recordHasMeas <= recM_nxt;
         recordMeas    <= recMe_nxt;
      end
   end

   // register file, one registered ack per mapped request, err for unmapped
   always_comb begin
      ctrl_nxt   = ctrl_r;
      posLvl_nxt = posLvl_r;
      decLvl_nxt = decLvl_r;
      ctrLvl_nxt = ctrLvl_r;
      len_nxt    = len_r;
      rdat_nxt   = wb_dat_o;
      mapped     = 1'b1;
      case (wb_adr_i)
         `REG_CTRL, `REG_POS_LEVEL, `REG_DEC_LEVEL, `REG_CENTER_LEVEL,
         `REG_PULSE_LEN, `REG_STATUS, `REG_CODE, `REG_MEAS, `REG_COUNT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      ack_nxt = wbReq && mapped;
      err_nxt = wbReq && !mapped;
      if (wbReq && mapped && wb_we_i) begin
         case (wb_adr_i)
            `REG_CTRL: if (wb_sel_i[0]) ctrl_nxt = {30'h0, wb_dat_i[1:0]};
            `REG_POS_LEVEL: if (wb_sel_i[0]) posLvl_nxt = wb_dat_i[`LEVEL_W-1:0];
            `REG_DEC_LEVEL: if (wb_sel_i[0]) decLvl_nxt = wb_dat_i[`LEVEL_W-1:0];
            `REG_CENTER_LEVEL: if (wb_sel_i[0]) ctrLvl_nxt = wb_dat_i[`LEVEL_W-1:0];
            `REG_PULSE_LEN: if (wb_sel_i[0]) len_nxt = wb_dat_i[LEN_W-1:0];
            default: ;
         endcase
      end
      if (wbReq && mapped && !wb_we_i) begin
         case (wb_adr_i)
            `REG_CTRL:         rdat_nxt = ctrl_r;
            `REG_POS_LEVEL:    rdat_nxt = {20'h0, posLvl_r};
            `REG_DEC_LEVEL:    rdat_nxt = {20'h0, decLvl_r};
            `REG_CENTER_LEVEL: rdat_nxt = {20'h0, ctrLvl_r};
            `REG_PULSE_LEN:    rdat_nxt = 32'(len_r);
            `REG_STATUS:       rdat_nxt = {27'h0, ackLevel, decoded_r, crossingPulse, state_r};
            `REG_CODE:         rdat_nxt = recordCode;
            `REG_MEAS:         rdat_nxt = recordMeas;
            `REG_COUNT:        rdat_nxt = {16'h0, count_r};
            default:           rdat_nxt = 32'h0000_0000;
         endcase
      end else if (wbReq) begin
         rdat_nxt = 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r   <= `CTRL_RESET;
         posLvl_r <= `POS_LEVEL_RESET;
         decLvl_r <= `DEC_LEVEL_RESET;
         ctrLvl_r <= `CENTER_RESET;
         len_r    <= LEN_W'(`PULSE_LEN_RESET);
         wb_dat_o <= 32'h0000_0000;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         ctrl_r   <= ctrl_nxt;
         posLvl_r <= posLvl_nxt;
         decLvl_r <= decLvl_nxt;
         ctrLvl_r <= ctrLvl_nxt;
         len_r    <= len_nxt;
         wb_dat_o <= rdat_nxt;
         wb_ack_o <= ack_nxt;
         wb_err_o <= err_nxt;
      end
   end

   // checks
   pulse_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_r == ARMED && state_nxt == PULSING) |-> rxLevel > posLvl_r)
      else $error("pulse started below positioning level");
   pulse_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(crossingPulse) |-> $past(decoded_r || goodCode))
      else $error("pulse without clean decode");
   pulse_center_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(crossingPulse) |-> $past(centerVolt) < $past(ctrLvl_r))
      else $error("pulse before center drop");
   pulse_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(crossingPulse) && len_r == LEN_W'(5) |-> crossingPulse [*5] ##1 !crossingPulse)
      else $error("pulse length wrong");
   rearm_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_r == SPENT && state_nxt == ARMED) |-> rxLevel < decLvl_r)
      else $error("rearmed above decoding level");
   one_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(crossingPulse) |-> state_r == SPENT)
      else $error("pulse ended without disarm");
   meas_append_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      recordValid && !recordHasMeas |-> recordMeas == '0)
      else $error("measurements leaked");
   code_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      goodCode |=> recordValid && recordCode == $past(codeIn))
      else $error("decoded code not presented");
   reset_armed_a: assert property (@(posedge sys_clk)
      $rose(resetn) |-> state_r == ARMED && !crossingPulse)
      else $error("not armed after reset");
endmodule : position_pulse_qualifier

// ==== shared/position_pulse_defs.svh ====
// constants for the crossing pulse qualifier
`ifndef POSITION_PULSE_DEFS_SVH
`define POSITION_PULSE_DEFS_SVH
`define LEVEL_W          12
`define CODE_W           32
`define MEAS_W           16
`define ADDR_W           8
// register offsets (byte addresses)
`define REG_CTRL         8'h00
`define REG_POS_LEVEL    8'h04
`define REG_DEC_LEVEL    8'h08
`define REG_CENTER_LEVEL 8'h0C
`define REG_PULSE_LEN    8'h10
`define REG_STATUS       8'h14
`define REG_CODE         8'h18
`define REG_MEAS         8'h1C
`define REG_COUNT        8'h20
// field positions
`define CTRL_APPEND_BIT  0
`define CTRL_ENABLE_BIT  1
// reset values
`define CTRL_RESET       32'h0000_0002
`define POS_LEVEL_RESET  12'h800
`define DEC_LEVEL_RESET  12'h400
`define CENTER_RESET     12'h100
`define PULSE_LEN_RESET  16'h03E8
`endif

// ==== shared/position_pulse_pkg.sv ====
// types for the crossing pulse qualifier
package position_pulse_pkg;
   typedef enum logic [1:0] {
      ARMED   = 2'b00,
      PULSING = 2'b01,
      SPENT   = 2'b10
   } qual_state_e;
endpackage : position_pulse_pkg

// ==== verification/tb_position_pulse_qualifier.sv ====
// self-checking bench for the crossing pulse qualifier
`timescale 1ns/1ps
`include "position_pulse_defs.svh"
module tb_position_pulse_qualifier;
   typedef struct {logic [11:0] rx; logic [11:0] ctr; logic err; int exp;} row_s;
   logic        sys_clk, resetn, codeValid, codeError, wbCyc, wbStb, wbWe, er;
   logic        recordValid, recordHasMeas, pulseAck, crossingPulse, wbAck, wbErr;
   logic [11:0] rxLevel, centerVolt;
   logic [31:0] codeIn, wbDat, rd, dutDat, recordCode, recordMeas;
   logic [15:0] supplyVolt, supplyCurr;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   int          n_mismatch, total_checks, pulseCount, lastLen, c0;
   row_s        rows[5];
   logic [7:0]  ra[5] = '{`REG_CTRL, `REG_POS_LEVEL, `REG_DEC_LEVEL, `REG_CENTER_LEVEL,
                          `REG_PULSE_LEN};
   logic [31:0] rv[5] = '{`CTRL_RESET, 32'(`POS_LEVEL_RESET), 32'(`DEC_LEVEL_RESET),
                          32'(`CENTER_RESET), 32'(`PULSE_LEN_RESET)};
   position_pulse_qualifier #(.LEN_W(16)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
      .rxLevel(rxLevel), .centerVolt(centerVolt), .codeValid(codeValid),
      .codeError(codeError), .codeIn(codeIn), .supplyVolt(supplyVolt),
      .supplyCurr(supplyCurr), .recordValid(recordValid), .recordCode(recordCode),
      .recordMeas(recordMeas), .recordHasMeas(recordHasMeas), .pulseAckPin(pulseAck),
      .crossingPulse(crossingPulse), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel), .wb_dat_o(dutDat),
      .wb_ack_o(wbAck), .wb_err_o(wbErr));
   vehicle_control_model ctl_u (.sys_clk(sys_clk), .crossingPulse(crossingPulse),
      .pulseAckPin(pulseAck), .pulseCount(pulseCount), .lastLen(lastLen));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle
   // no cycle count is assumed: the bounded loop only guards against a hang
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      wbSel <= 4'hF;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20);
      rd = dutDat;
      er = wbErr;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (wbAck !== 1'b1 && wbErr !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
   endtask : wb
   task automatic sendCode(input logic [31:0] c, input logic e);
      @(posedge sys_clk);
      codeValid <= 1'b1;
      codeIn <= c;
      codeError <= e;
      @(posedge sys_clk);
      codeValid <= 1'b0;
      @(posedge sys_clk);
      chk(recordValid, !e, "record valid");
      if (!e) chk(recordCode, c, "record code");
   endtask : sendCode
   // one crossing: level up, code read far from center, then center reached
   task automatic pass(input logic [11:0] rx, input logic [11:0] ctr, input logic e);
      @(posedge sys_clk);
      rxLevel <= rx;
      centerVolt <= 12'hFFF;
      sendCode({20'h5A5A5, rx}, e);
      centerVolt <= ctr;
      idle(12);
   endtask : pass
   initial begin
      {resetn, codeValid, codeError, wbCyc, wbStb, wbWe} = 6'h0;
      {rxLevel, centerVolt, codeIn, wbDat, wbAdr, wbSel} = '0;
      supplyVolt = 16'h1234;
      supplyCurr = 16'hABCD;
      {n_mismatch, total_checks} = '0;
      rows = '{'{12'h900, 12'h080, 1'b0, 1}, '{12'h800, 12'h080, 1'b0, 0},
               '{12'h900, 12'h080, 1'b1, 0}, '{12'h900, 12'h100, 1'b0, 0},
               '{12'h801, 12'h0FF, 1'b0, 1}};
      idle(5);
      resetn <= 1'b1;
      idle(1);
      chk(crossingPulse, 1'b0, "pulse idle");
      foreach (ra[i]) begin
         wb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i], "reset value");
      end
      wb(1'b0, 8'h24, 32'h0);
      chk(er, 1'b1, "unmapped err");
      wb(1'b1, `REG_PULSE_LEN, 32'h5);
      wb(1'b0, `REG_PULSE_LEN, 32'h0);
      chk(rd, 32'h5, "length readback");
      sendCode(32'h1111_0000, 1'b0);
      chk({recordHasMeas, recordMeas}, 33'h0, "no append");
      foreach (rows[i]) begin
         rxLevel <= 12'h0;
         idle(4);
         c0 = pulseCount;
         pass(rows[i].rx, rows[i].ctr, rows[i].err);
         chk(pulseCount - c0, rows[i].exp, "pulse count");
         if (rows[i].exp == 1) chk(lastLen, 32'h5, "pulse length");
      end
      // vehicle stops over the transponder and reverses across the center
      c0 = pulseCount;
      rxLevel <= 12'h500;
      idle(3);
      pass(12'h900, 12'h080, 1'b0);
      chk(pulseCount - c0, 32'h0, "reversal");
      rxLevel <= 12'h3FF;
      idle(4);
      pass(12'h900, 12'h080, 1'b0);
      chk(pulseCount - c0, 32'h1, "rearmed");
      wb(1'b0, `REG_COUNT, 32'h0);
      chk(rd, 32'h3, "pulse total");
      // enable off: a fully qualified crossing must stay silent
      wb(1'b1, `REG_CTRL, 32'h1);
      rxLevel <= 12'h0;
      idle(4);
      c0 = pulseCount;
      pass(12'h900, 12'h080, 1'b0);
      chk(pulseCount - c0, 32'h0, "disabled");
      rxLevel <= 12'h0;
      wb(1'b1, `REG_CTRL, 32'h3);
      sendCode(32'hCAFE_0001, 1'b0);
      chk({recordHasMeas, recordMeas}, 33'h1_1234_ABCD, "append");
      wb(1'b0, `REG_MEAS, 32'h0);
      chk(rd, 32'h1234_ABCD, "meas readback");
      wb(1'b0, `REG_CODE, 32'h0);
      chk(rd, 32'hCAFE_0001, "code readback");
      // long pulse: status read mid-pulse sees the synchronised return pin
      wb(1'b1, `REG_PULSE_LEN, 32'h28);
      pass(12'h900, 12'h080, 1'b0);
      wb(1'b0, `REG_STATUS, 32'h0);
      chk(rd, 32'h1D, "status in pulse");
      idle(40);
      chk(lastLen, 32'h28, "long pulse");
      wb(1'b0, `REG_STATUS, 32'h0);
      chk(rd, 32'h0A, "status spent");
      conclude();
   end
endmodule : tb_position_pulse_qualifier

// ==== verification/vehicle_control_model.sv ====
// vehicle control model that receives the crossing pulse
`timescale 1ns/1ps
module vehicle_control_model (
   // clock
   input  wire logic sys_clk,
   // pulse from the device
   input  wire logic crossingPulse,
   // acknowledge pin back to the device
   output logic      pulseAckPin,
   // observations for the bench
   output int        pulseCount,
   output int        lastLen
);
   int   run  = 0;
   int   cnt  = 0;
   int   len  = 0;
   logic ackQ = 1'b0;
   assign pulseAckPin = ackQ;
   assign pulseCount  = cnt;
   assign lastLen     = len;
   // position is latched at the rise; direction correction is ours, the device cannot know it
   always @(posedge sys_clk) begin
      ackQ <= crossingPulse;
      if (crossingPulse && run == 0)
         cnt <= cnt + 1;
      if (crossingPulse)
         run <= run + 1;
      else if (run != 0) begin
         len <= run;
         run <= 0;
      end
   end
endmodule : vehicle_control_model
